// [design/rei_pkg.sv]
package rei_pkg;

  // bus geometry
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IDX_W      = 8;
  localparam int unsigned IDX_LSB    = 2;
  localparam int unsigned IDX_MSB    = 9;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CONTROL        = 8'h00;
  localparam logic [7:0] IDX_EVENT_OUT_EN   = 8'h04;
  localparam logic [7:0] IDX_IRQ_EN_CLR     = 8'h06;
  localparam logic [7:0] IDX_IRQ_EN_SET     = 8'h07;
  localparam logic [7:0] IDX_IRQ_STATUS     = 8'h08;
  localparam logic [7:0] IDX_IRQ_STATUS_CLR = 8'h09;
  localparam logic [7:0] IDX_WRITE_LOCK     = 8'h0A;

  // event output enable fields
  localparam int unsigned EV_W          = 16;
  localparam int unsigned PER_W         = 8;
  localparam int unsigned BIT_OVF_EV    = 15;
  localparam int unsigned BIT_CMP1_EV   = 9;
  localparam int unsigned BIT_COMPARE_ZERO_IRQ_EN_EV   = 8;
  localparam int unsigned BIT_ALARM_EV  = 8;
  localparam logic [15:0] EV_RST        = 16'h0000;
  localparam logic [15:0] EV_MASK_HALF  = 16'h83FF;
  localparam logic [15:0] EV_MASK_ONE   = 16'h81FF;
  localparam logic [15:0] EV_MASK_RSVD  = 16'h80FF;

  // interrupt enable and status fields
  localparam int unsigned IRQ_W         = 8;
  localparam int unsigned IRQ_OVF       = 7;
  localparam int unsigned IRQ_SYNC      = 6;
  localparam int unsigned IRQ_CMP1      = 1;
  localparam int unsigned IRQ_COMPARE_ZERO_IRQ_EN      = 0;
  localparam logic [7:0]  IRQ_RST       = 8'h00;
  localparam logic [7:0]  IRQ_MASK_HALF = 8'hC3;
  localparam logic [7:0]  IRQ_MASK_ONE  = 8'hC1;
  localparam logic [7:0]  IRQ_MASK_RSVD = 8'hC0;

  // control fields
  localparam int unsigned CTRL_EN       = 1;
  localparam int unsigned CTRL_MODE_LO  = 2;
  localparam int unsigned CTRL_MODE_HI  = 3;
  localparam int unsigned LOCK_BIT      = 0;

  typedef enum logic [1:0] {
    wide_counter_mode = 2'b00,
    half_counter_mode = 2'b01,
    calendar_mode     = 2'b10,
    reserved_mode     = 2'b11
  } rei_mode_t;

  // event enable bits that exist in a mode
  function automatic logic [15:0] rei_ev_mask(input rei_mode_t m);
    case (m)
      half_counter_mode: rei_ev_mask = EV_MASK_HALF;
      wide_counter_mode: rei_ev_mask = EV_MASK_ONE;
      calendar_mode:     rei_ev_mask = EV_MASK_ONE;
      default:           rei_ev_mask = EV_MASK_RSVD;
    endcase
  endfunction

  // interrupt enable bits that exist in a mode
  function automatic logic [7:0] rei_irq_mask(input rei_mode_t m);
    case (m)
      half_counter_mode: rei_irq_mask = IRQ_MASK_HALF;
      wide_counter_mode: rei_irq_mask = IRQ_MASK_ONE;
      calendar_mode:     rei_irq_mask = IRQ_MASK_ONE;
      default:           rei_irq_mask = IRQ_MASK_RSVD;
    endcase
  endfunction

  function automatic logic rei_is_mapped(input logic [7:0] idx);
    rei_is_mapped = (idx == IDX_CONTROL) || (idx == IDX_EVENT_OUT_EN) ||
                    (idx == IDX_IRQ_EN_CLR) || (idx == IDX_IRQ_EN_SET) ||
                    (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_STATUS_CLR) ||
                    (idx == IDX_WRITE_LOCK);
  endfunction

endpackage

// [design/rei_apb_slave.sv]
`timescale 1ns/1ps
module rei_apb_slave
  import rei_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic      [IDX_W-1:0]  idx,
  output logic                   setup_rd,
  output logic                   wr_stb,
  output logic                   pready,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pslverr
);

  logic              hit;
  logic              setup;
  logic              next_pready;
  logic              next_pslverr;
  logic [DATA_W-1:0] next_prdata;

  // decode: aligned word inside the map only
  always_comb begin
    idx   = paddr[IDX_MSB:IDX_LSB];
    hit   = (paddr[IDX_LSB-1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_MSB+1] == 2'h0) &&
            rei_is_mapped(idx);
    setup = psel && !penable;
    setup_rd = setup && !pwrite;
    // write lands only at the access edge where pready is seen high
    wr_stb = psel && penable && pwrite && pready && !pslverr;
  end

  // one wait-free access phase; read data captured at the setup edge
  always_comb begin
    next_pready  = setup;
    next_pslverr = setup && !hit;
    next_prdata  = prdata;
    if (setup_rd) begin
      next_prdata = hit ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

endmodule

// [design/rei_event_gate.sv]
`timescale 1ns/1ps
module rei_event_gate
  import rei_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire rei_mode_t        mode,
  input  wire logic [EV_W-1:0]  ev_en,
  input  wire logic             overflow_in,
  input  wire logic [1:0]       compare_match_in,
  input  wire logic             alarm_match_in,
  input  wire logic [PER_W-1:0] periodic_in,
  output logic                  overflow_event,
  output logic      [1:0]       compare_event,
  output logic                  alarm_event,
  output logic      [PER_W-1:0] periodic_event
);

  logic             next_ovf;
  logic [1:0]       next_cmp;
  logic             next_alarm;
  logic [PER_W-1:0] next_per;

  // each event output is the raw strobe gated by its enable, one cycle late
  always_comb begin
    next_ovf   = overflow_in && ev_en[BIT_OVF_EV];
    next_cmp   = 2'b00;
    next_alarm = 1'b0;
    if (mode == half_counter_mode) begin
      next_cmp = compare_match_in & ev_en[BIT_CMP1_EV:BIT_COMPARE_ZERO_IRQ_EN_EV];
    end else if (mode == wide_counter_mode) begin
      next_cmp[0] = compare_match_in[0] && ev_en[BIT_COMPARE_ZERO_IRQ_EN_EV];
    end else if (mode == calendar_mode) begin
      next_alarm = alarm_match_in && ev_en[BIT_ALARM_EV];
    end
    next_per = periodic_in & ev_en[PER_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_event <= 1'b0;
      compare_event  <= 2'b00;
      alarm_event    <= 1'b0;
      periodic_event <= 8'h00;
    end else begin
      overflow_event <= next_ovf;
      compare_event  <= next_cmp;
      alarm_event    <= next_alarm;
      periodic_event <= next_per;
    end
  end

endmodule

// [design/rei_top.sv]
// Notes on behaviour
// - overflow event output follows every overflow while enable bit 15 is one
// - half counter mode: bits 9 and 8 gate compare 1 and 0 events
// - bits 7 to 0 gate the eight periodic interval events
// - calendar mode: bit 8 gates the alarm 0 event
// - event enable register at index 0x04, resets to zero, layout per mode
// - interrupt enable clear register at index 0x06, eight bits, resets to zero
// - writing zero to an enable clear bit changes nothing
// - writing one to clear bit 7 disables the overflow interrupt
// - writing one to clear bit 6 disables the sync ready interrupt
// - wide counter mode: clear bit 0 disables compare 0 interrupt
// - interrupt raised when a flag is set and its enable is one
// - reading the clear register returns the current enable bits
// - half counter mode: clear bits 1 and 0 disable compare 1 and 0
// - mode field: 0 wide counter, 1 half counter, 2 calendar, 3 reserved
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module rei_top
  import rei_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              overflow_in,
  input  wire logic              sync_ready_in,
  input  wire logic [1:0]        compare_match_in,
  input  wire logic              alarm_match_in,
  input  wire logic [PER_W-1:0]  periodic_in,
  output logic                   overflow_event,
  output logic      [1:0]        compare_event,
  output logic                   alarm_event,
  output logic      [PER_W-1:0]  periodic_event,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic [IDX_W-1:0]  idx;
  logic              setup_rd;
  logic              wr_stb;
  logic [DATA_W-1:0] rd_data;

  rei_apb_slave u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .rd_data  (rd_data),
    .idx      (idx),
    .setup_rd (setup_rd),
    .wr_stb   (wr_stb),
    .pready   (pready),
    .prdata   (prdata),
    .pslverr  (pslverr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register state

  rei_mode_t        mode;
  logic             ctrl_enable;
  logic             write_lock;
  logic [EV_W-1:0]  ev_en;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_flags;

  rei_mode_t        next_mode;
  logic             next_ctrl_enable;
  logic             next_write_lock;
  logic [EV_W-1:0]  next_ev_en;
  logic [IRQ_W-1:0] next_irq_en;
  logic [IRQ_W-1:0] next_irq_flags;
  logic             next_irq;

  logic             wr_ctrl;
  logic             wr_ev;
  logic             wr_en_clr;
  logic             wr_en_set;
  logic             wr_flag_clr;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] wdata8;

  // per-register write strobes
  always_comb begin
    wdata8      = pwdata[IRQ_W-1:0];
    wr_ctrl     = wr_stb && (idx == IDX_CONTROL) && !write_lock;
    wr_ev       = wr_stb && (idx == IDX_EVENT_OUT_EN);
    wr_en_clr   = wr_stb && (idx == IDX_IRQ_EN_CLR) && !write_lock;
    wr_en_set   = wr_stb && (idx == IDX_IRQ_EN_SET) && !write_lock;
    wr_flag_clr = wr_stb && (idx == IDX_IRQ_STATUS_CLR);
  end

  // control: mode only changes while the counter is stopped
  always_comb begin
    next_mode        = mode;
    next_ctrl_enable = ctrl_enable;
    next_write_lock  = write_lock;
    if (wr_ctrl) begin
      next_ctrl_enable = pwdata[CTRL_EN];
      if (!ctrl_enable) begin
        next_mode = rei_mode_t'(pwdata[CTRL_MODE_HI:CTRL_MODE_LO]);
      end
    end
    // lock register itself stays writable so software can release it
    if (wr_stb && (idx == IDX_WRITE_LOCK)) begin
      next_write_lock = pwdata[LOCK_BIT];
    end
  end

  // event output enables
  always_comb begin
    next_ev_en = ev_en;
    if (wr_ev && !ctrl_enable && !write_lock) begin
      next_ev_en = pwdata[EV_W-1:0] & rei_ev_mask(mode);
    end
  end

  // one enable store behind both set and clear views
  always_comb begin
    next_irq_en = irq_en;
    if (wr_en_set) begin
      next_irq_en = irq_en | (wdata8 & rei_irq_mask(mode));
    end
    // enable clear for every bit that exists in the mode
    if (wr_en_clr) begin
      next_irq_en = irq_en & ~(wdata8 & rei_irq_mask(mode));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and request

  // raw sources per mode; bit 0 is compare 0 or alarm 0
  always_comb begin
    irq_set           = 8'h00;
    irq_set[IRQ_OVF]  = overflow_in;
    irq_set[IRQ_SYNC] = sync_ready_in;
    if (mode == half_counter_mode) begin
      irq_set[IRQ_CMP1] = compare_match_in[1];
      irq_set[IRQ_COMPARE_ZERO_IRQ_EN] = compare_match_in[0];
    end else if (mode == wide_counter_mode) begin
      irq_set[IRQ_COMPARE_ZERO_IRQ_EN] = compare_match_in[0];
    end else if (mode == calendar_mode) begin
      irq_set[IRQ_COMPARE_ZERO_IRQ_EN] = alarm_match_in;
    end
  end

  // sticky flags; a new event beats a clear in the same cycle
  always_comb begin
    next_irq_flags = irq_flags;
    if (wr_flag_clr) begin
      next_irq_flags = irq_flags & ~wdata8;
    end
    next_irq_flags = next_irq_flags | irq_set;
    // request while an enabled flag is set
    next_irq = |(irq_flags & irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode        <= wide_counter_mode;
      ctrl_enable <= 1'b0;
      write_lock  <= 1'b0;
      ev_en       <= EV_RST;
      irq_en      <= IRQ_RST;
      irq_flags   <= IRQ_RST;
      irq         <= 1'b0;
    end else begin
      mode        <= next_mode;
      ctrl_enable <= next_ctrl_enable;
      write_lock  <= next_write_lock;
      ev_en       <= next_ev_en;
      irq_en      <= next_irq_en;
      irq_flags   <= next_irq_flags;
      irq         <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rd_data = 32'h0000_0000;
    if (idx == IDX_CONTROL) begin
      rd_data[CTRL_MODE_HI:CTRL_MODE_LO] = mode;
      rd_data[CTRL_EN]                   = ctrl_enable;
    end else if (idx == IDX_EVENT_OUT_EN) begin
      rd_data[EV_W-1:0] = ev_en & rei_ev_mask(mode);
    end else if ((idx == IDX_IRQ_EN_CLR) || (idx == IDX_IRQ_EN_SET)) begin
      rd_data[IRQ_W-1:0] = irq_en & rei_irq_mask(mode);
    end else if (idx == IDX_IRQ_STATUS) begin
      rd_data[IRQ_W-1:0] = irq_flags;
    end else if (idx == IDX_WRITE_LOCK) begin
      rd_data[LOCK_BIT] = write_lock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event outputs

  rei_event_gate u_gate (
    .pclk             (pclk),
    .presetn          (presetn),
    .mode             (mode),
    .ev_en            (ev_en),
    .overflow_in      (overflow_in),
    .compare_match_in (compare_match_in),
    .alarm_match_in   (alarm_match_in),
    .periodic_in      (periodic_in),
    .overflow_event   (overflow_event),
    .compare_event    (compare_event),
    .alarm_event      (alarm_event),
    .periodic_event   (periodic_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_OVF_EV_ON: assert property (
    overflow_in && ev_en[BIT_OVF_EV] |=> overflow_event)
    else $error("overflow event missing");

  AST_OVF_EV_OFF: assert property (
    overflow_event |-> $past(overflow_in) && $past(ev_en[BIT_OVF_EV]))
    else $error("overflow event without cause");

  AST_CMP_EV: assert property (
    (mode == half_counter_mode) && compare_match_in[1] && ev_en[BIT_CMP1_EV]
    |=> compare_event[1])
    else $error("compare 1 event missing");

  AST_PER_EV: assert property (
    ##1 (periodic_event & ~$past(periodic_in & ev_en[PER_W-1:0])) == 8'h00)
    else $error("periodic event while disabled");

  AST_ALARM_EV: assert property (
    alarm_event |-> $past(alarm_match_in && ev_en[BIT_ALARM_EV] && (mode == calendar_mode)))
    else $error("alarm event without enabled match");

  AST_EV_PROTECT: assert property (
    wr_ev && (ctrl_enable || write_lock) |=> $stable(ev_en))
    else $error("event enable changed while protected");

  AST_CLR_ZERO: assert property (
    wr_en_clr && (wdata8 == 8'h00) |=> $stable(irq_en))
    else $error("zero write changed enables");

  AST_CLR_OVF: assert property (
    wr_en_clr && wdata8[IRQ_OVF] |=> !irq_en[IRQ_OVF])
    else $error("overflow enable not cleared");

  AST_CLR_SYNC: assert property (
    wr_en_clr && wdata8[IRQ_SYNC] |=> !irq_en[IRQ_SYNC])
    else $error("sync ready enable not cleared");

  AST_CLR_COMPARE_ZERO_IRQ_EN: assert property (
    wr_en_clr && wdata8[IRQ_COMPARE_ZERO_IRQ_EN] && (mode == wide_counter_mode) |=> !irq_en[IRQ_COMPARE_ZERO_IRQ_EN])
    else $error("compare 0 enable not cleared");

  AST_CLR_CMP1: assert property (
    wr_en_clr && wdata8[IRQ_CMP1] && (mode == half_counter_mode) |=> !irq_en[IRQ_CMP1])
    else $error("compare 1 enable not cleared");

  AST_IRQ: assert property (
    ##1 irq == $past(|(irq_flags & irq_en)))
    else $error("interrupt line disagrees with flags");

  AST_RD_EN: assert property (
    setup_rd && (idx == IDX_IRQ_EN_CLR) && (paddr[IDX_LSB-1:0] == 2'h0) &&
    (paddr[ADDR_W-1:IDX_MSB+1] == 2'h0)
    |=> prdata[IRQ_W-1:0] == $past(irq_en & rei_irq_mask(mode)))
    else $error("enable read-back wrong");

  COV_OVF_EV: cover property (overflow_event);
  COV_IRQ: cover property (!irq ##1 irq);
  COV_CLR_WR: cover property (wr_en_clr && (wdata8 != 8'h00));
  COV_HALF_CMP1: cover property (compare_event[1]);

endmodule

// [sim/rtc_event_irq_enable_regs_test.sv]
`timescale 1ns/1ps
module rtc_event_irq_enable_regs_test
  import rei_pkg::*;
;
  localparam int LIMIT = 5000;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              overflow_in;
  logic              sync_ready_in;
  logic [1:0]        compare_match_in;
  logic              alarm_match_in;
  logic [PER_W-1:0]  periodic_in;
  logic              overflow_event;
  logic [1:0]        compare_event;
  logic              alarm_event;
  logic [PER_W-1:0]  periodic_event;
  logic              irq;
  int                n_mismatch = 0;
  int                compares   = 0;
  int                cycles     = 0;
  logic [15:0]       ev;
  logic [7:0]        en;
  logic [31:0]       rv;
  logic [31:0]       cv;
  logic              ev_err;

  rei_top i_dut (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .overflow_in      (overflow_in),
    .sync_ready_in    (sync_ready_in),
    .compare_match_in (compare_match_in),
    .alarm_match_in   (alarm_match_in),
    .periodic_in      (periodic_in),
    .overflow_event   (overflow_event),
    .compare_event    (compare_event),
    .alarm_event      (alarm_event),
    .periodic_event   (periodic_event),
    .irq              (irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial pclk = 1'h0;
  always #25 pclk = ~pclk;

  // hang guard, generous against a few hundred cycles of traffic
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("MISMATCH timeout expected finish seen hang");
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // expectations, kept apart from the design's own helpers
  function automatic logic [15:0] evm(input int m);
    case (m)
      1:       evm = EV_MASK_HALF;
      0, 2:    evm = EV_MASK_ONE;
      default: evm = EV_MASK_RSVD;
    endcase
  endfunction

  function automatic logic [7:0] irm(input int m);
    case (m)
      1:       irm = IRQ_MASK_HALF;
      0, 2:    irm = IRQ_MASK_ONE;
      default: irm = IRQ_MASK_RSVD;
    endcase
  endfunction

  // ir packs overflow, compare 1..0, alarm, periodic 7..0
  function automatic logic [11:0] gate(input int m, input logic [15:0] e, input logic [11:0] ir);
    logic [1:0] c;
    c = (m == 1) ? e[9:8] : (m == 0) ? {1'h0, e[8]} : 2'h0;
    gate = {ir[11] & e[15], ir[10:9] & c, ir[8] & e[8] & (m == 2), ir[7:0] & e[7:0]};
  endfunction

  function automatic logic [7:0] flags(input int m, input logic [11:0] ir, input logic s);
    flags = {ir[11], s, 4'h0, ir[10] & (m == 1), (m == 2) ? ir[8] : ir[9] & (m < 2)};
  endfunction

  function automatic logic [ADDR_W-1:0] ra(input logic [7:0] idx);
    ra = {2'h0, idx, 2'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    // pready sampled high ends this wait; the hang guard ends it if pready never rises
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1);
    chk("pready wait", 32'h1, 32'(n));
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, ra(idx), d, r, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'h0, ra(idx), 32'h0, r, e);
    chk(what, exp, r);
    chk({what, " error"}, 32'h0, {31'h0, e});
  endtask

  // random strobes for one cycle, then events, irq and flags are compared
  task automatic pulse(input int m, input logic [15:0] e, input logic [7:0] ie);
    logic [11:0] ir;
    logic        s;
    logic [7:0]  fl;
    ir = 12'($urandom);
    s = 1'($urandom);
    fl = flags(m, ir, s);
    @(posedge pclk);
    {overflow_in, compare_match_in, alarm_match_in, periodic_in} <= ir;
    sync_ready_in <= s;
    @(posedge pclk);
    {overflow_in, compare_match_in, alarm_match_in, periodic_in} <= 12'h0;
    sync_ready_in <= 1'h0;
    #1;
    chk("events", {20'h0, gate(m, e, ir)},
        {20'h0, overflow_event, compare_event, alarm_event, periodic_event});
    @(posedge pclk);
    #1;
    chk("irq", {31'h0, |(fl & ie)}, {31'h0, irq});
    rd_chk("status", IDX_IRQ_STATUS, {24'h0, fl});
    wr(IDX_IRQ_STATUS_CLR, 32'hFF);
    rd_chk("status cleared", IDX_IRQ_STATUS, 32'h0);
    chk("irq idle", 32'h0, {31'h0, irq});
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn          = 1'h0;
    psel             = 1'h0;
    penable          = 1'h0;
    pwrite           = 1'h0;
    paddr            = 12'h0;
    pwdata           = 32'h0;
    overflow_in      = 1'h0;
    sync_ready_in    = 1'h0;
    compare_match_in = 2'h0;
    alarm_match_in   = 1'h0;
    periodic_in      = 8'h0;
    void'($urandom(10820));
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    // reset values of both registers and the irq output
    rd_chk("event enable reset", IDX_EVENT_OUT_EN, 32'h0);
    rd_chk("enable clear reset", IDX_IRQ_EN_CLR, 32'h0);
    chk("irq reset", 32'h0, {31'h0, irq});
    $display("test reset done");
    // every mode: layout masks, shared enable storage, clear semantics, gating
    for (int m = 0; m < 4; m++) begin
      wr(IDX_CONTROL, 32'(m) << 2);
      rv = $urandom;
      ev = rv[15:0] & evm(m);
      wr(IDX_EVENT_OUT_EN, rv);
      rd_chk("event enable", IDX_EVENT_OUT_EN, {16'h0, ev});
      rv = $urandom;
      en = rv[7:0] & irm(m);
      wr(IDX_IRQ_EN_SET, rv);
      rd_chk("enable via clear view", IDX_IRQ_EN_CLR, {24'h0, en});
      rd_chk("enable via set view", IDX_IRQ_EN_SET, {24'h0, en});
      wr(IDX_IRQ_EN_CLR, 32'h0);
      rd_chk("clear with zeros", IDX_IRQ_EN_CLR, {24'h0, en});
      wr(IDX_IRQ_EN_SET, 32'hFF);
      cv = $urandom;
      en = irm(m) & ~cv[7:0];
      wr(IDX_IRQ_EN_CLR, cv);
      rd_chk("clear with ones", IDX_IRQ_EN_CLR, {24'h0, en});
      repeat (4) pulse(m, ev, en);
      // corner: everything cleared, no source may raise irq
      wr(IDX_IRQ_EN_CLR, 32'hFF);
      en = 8'h0;
      rd_chk("all cleared", IDX_IRQ_EN_CLR, 32'h0);
      pulse(m, ev, en);
      $display("test mode %0d done", m);
    end
    // protection: enabled peripheral and write lock both freeze the event enables
    wr(IDX_CONTROL, 32'h6);
    wr(IDX_EVENT_OUT_EN, 32'hFFFF);
    rd_chk("enabled write ignored", IDX_EVENT_OUT_EN, {16'h0, ev});
    wr(IDX_CONTROL, 32'h4);
    wr(IDX_WRITE_LOCK, 32'h1);
    wr(IDX_EVENT_OUT_EN, 32'hFFFF);
    rd_chk("locked write ignored", IDX_EVENT_OUT_EN, {16'h0, ev});
    wr(IDX_IRQ_EN_SET, 32'hFF);
    rd_chk("locked set ignored", IDX_IRQ_EN_CLR, 32'h0);
    wr(IDX_WRITE_LOCK, 32'h0);
    wr(IDX_EVENT_OUT_EN, 32'hFFFF);
    rd_chk("unlocked write", IDX_EVENT_OUT_EN, {16'h0, EV_MASK_HALF});
    $display("test protection done");
    // refused: unmapped index and misaligned address
    apb(1'h0, 12'h03C, 32'h0, rv, ev_err);
    chk("unmapped error", 32'h1, {31'h0, ev_err});
    chk("unmapped data", 32'h0, rv);
    apb(1'h1, ra(IDX_EVENT_OUT_EN) | 12'h001, 32'h0, rv, ev_err);
    chk("misaligned error", 32'h1, {31'h0, ev_err});
    rd_chk("misaligned dropped", IDX_EVENT_OUT_EN, {16'h0, EV_MASK_HALF});
    $display("test refusal done");
    tally_and_finish();
  end
endmodule
